// file: hw/bit_sync.sv
// Two-stage synchroniser for a bundle of slowly changing levels.
// Assumes each bit is independently meaningful, or held stable across the crossing.
`timescale 1ns/100ps
`default_nettype none
module bit_sync #(
   parameter int WIDTH = 1
) (
   input wire logic i_clock,
   input wire logic i_rstn,
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);

   logic [WIDTH-1:0] meta_q;

   // The first stage is read only by the second one.
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         meta_q <= '0;
         o_sync <= '0;
      end else begin
         meta_q <= i_async;
         o_sync <= meta_q;
      end
   end

endmodule : bit_sync
`default_nettype wire

// file: hw/jtag_tap.sv
// Test access port with sixteen-state controller, instruction, identification,
// bypass and boundary scan registers. Assumes the tester owns the test clock,
// which may stop between scans, and that pin levels arrive from the core domain.
//
// Overview of operation
// - Scan data enters on test data in and leaves on test data out, timed by test clock.
// - Sixteen-state controller advances on test mode select at each rising test clock while the enable is set.
// - Three-bit instruction register, shifted in least significant bit first.
// - Code 000 puts the boundary chain between data in and data out.
// - Under code 000, output pins follow the boundary chain's updated contents.
// - Code 100 selects the chain while pins keep their normal core path.
// - With the chain selected, Capture-DR loads pin values, Shift-DR moves them out.
// - Code 110 puts the identification register between data in and data out.
// - Code 111 passes data through with exactly one test clock of delay.
// - The identification register is 32 bits and bit zero reads one.
// - Identification bits 1-11 maker, 12-27 part, 28-31 revision.
// - The identification code shifts out least significant bit first.
// - The bypass bit is one stage skipping the boundary chain.
// - The boundary chain has 98 stages, used by codes 000 and 100.
// - Five rising edges with mode select high and the enable set reach reset; instruction becomes 110.
// - Chain holding stage latches on falling clock in Update-DR only.
// - Idle holds while mode select is low; high goes to Select-DR-Scan.
`timescale 1ns/100ps
`default_nettype none
module jtag_tap #(
   parameter logic [10:0] MANUF_ID = 11'h055, // Arbitrary value.
   parameter logic [15:0] PART_ID = 16'h1234, // Arbitrary value.
   parameter logic [3:0] REVISION_ID = 4'h1 // Arbitrary value.
) (
   input wire logic i_clock,
   input wire logic i_rstn,
   input wire logic i_clock_en,
   input wire logic i_tck,
   input wire logic i_tms,
   input wire logic i_tdi,
   output logic o_tdo,
   output logic o_tdo_oe,
   input wire logic [tap_pkg::CHAIN_LEN-1:0] i_pin_level,
   input wire logic [tap_pkg::CHAIN_LEN-1:0] i_core_drive,
   output logic [tap_pkg::CHAIN_LEN-1:0] o_pin_drive
);

   localparam int N = tap_pkg::CHAIN_LEN;

   tap_pkg::tap_state_t state_q;
   tap_pkg::tap_state_t state_d;
   tap_pkg::dr_sel_t dr_sel;
   tap_pkg::idcode_t id_value;
   logic tck_en;
   logic [N-1:0] pin_sync;
   logic [2:0] ir_q;
   logic [2:0] ir_shift_q;
   logic [tap_pkg::ID_LEN-1:0] id_shift_q;
   logic bypass_q;
   logic [N-1:0] chain_q;
   logic [N-1:0] update_hold_q;
   logic update_tgl_q;
   logic extest_q;
   logic serial_out;
   logic [1:0] core_sync;
   logic update_seen_q;
   logic [N-1:0] pin_hold_q;

   assign id_value = '{revision: REVISION_ID, part: PART_ID, manufacturer: MANUF_ID, one: 1'b1};

   // The enable and the pin levels come from the core domain, so they are
   // brought into the test clock domain before any controller logic sees them.
   bit_sync #(.WIDTH(1)) en_sync_u (
      .i_clock(i_tck),
      .i_rstn(i_rstn),
      .i_async(i_clock_en),
      .o_sync(tck_en)
   );

   bit_sync #(.WIDTH(N)) pin_sync_u (
      .i_clock(i_tck),
      .i_rstn(i_rstn),
      .i_async(i_pin_level),
      .o_sync(pin_sync)
   );

   // Next controller state from the present mode select level.
   always_comb begin
      case (state_q)
         tap_pkg::ST_RESET: state_d = i_tms ? tap_pkg::ST_RESET : tap_pkg::ST_IDLE;
         tap_pkg::ST_IDLE: state_d = i_tms ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
         tap_pkg::ST_SEL_DR: state_d = i_tms ? tap_pkg::ST_SEL_IR : tap_pkg::ST_CAP_DR;
         tap_pkg::ST_CAP_DR: state_d = i_tms ? tap_pkg::ST_EXIT1_DR : tap_pkg::ST_SHIFT_DR;
         tap_pkg::ST_SHIFT_DR: state_d = i_tms ? tap_pkg::ST_EXIT1_DR : tap_pkg::ST_SHIFT_DR;
         tap_pkg::ST_EXIT1_DR: state_d = i_tms ? tap_pkg::ST_UPD_DR : tap_pkg::ST_PAUSE_DR;
         tap_pkg::ST_PAUSE_DR: state_d = i_tms ? tap_pkg::ST_EXIT2_DR : tap_pkg::ST_PAUSE_DR;
         tap_pkg::ST_EXIT2_DR: state_d = i_tms ? tap_pkg::ST_UPD_DR : tap_pkg::ST_SHIFT_DR;
         tap_pkg::ST_UPD_DR: state_d = i_tms ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
         tap_pkg::ST_SEL_IR: state_d = i_tms ? tap_pkg::ST_RESET : tap_pkg::ST_CAP_IR;
         tap_pkg::ST_CAP_IR: state_d = i_tms ? tap_pkg::ST_EXIT1_IR : tap_pkg::ST_SHIFT_IR;
         tap_pkg::ST_SHIFT_IR: state_d = i_tms ? tap_pkg::ST_EXIT1_IR : tap_pkg::ST_SHIFT_IR;
         tap_pkg::ST_EXIT1_IR: state_d = i_tms ? tap_pkg::ST_UPD_IR : tap_pkg::ST_PAUSE_IR;
         tap_pkg::ST_PAUSE_IR: state_d = i_tms ? tap_pkg::ST_EXIT2_IR : tap_pkg::ST_PAUSE_IR;
         tap_pkg::ST_EXIT2_IR: state_d = i_tms ? tap_pkg::ST_UPD_IR : tap_pkg::ST_SHIFT_IR;
         tap_pkg::ST_UPD_IR: state_d = i_tms ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
         default: state_d = tap_pkg::ST_RESET;
      endcase
   end

   // Controller state register; every path with mode select high ends in reset
   // within five edges, which is what lets the tester recover blindly.
   always_ff @(posedge i_tck or negedge i_rstn) begin
      if (!i_rstn) begin
         state_q <= tap_pkg::ST_RESET;
      end else if (tck_en) begin
         state_q <= state_d;
      end
   end

   // Instruction decode; anything not defined falls back to the bypass bit.
   always_comb begin
      case (ir_q)
         tap_pkg::IR_EXTEST: dr_sel = tap_pkg::SEL_CHAIN;
         tap_pkg::IR_SAMPLE: dr_sel = tap_pkg::SEL_CHAIN;
         tap_pkg::IR_IDCODE: dr_sel = tap_pkg::SEL_ID;
         tap_pkg::IR_BYPASS: dr_sel = tap_pkg::SEL_BYPASS;
         default: dr_sel = tap_pkg::SEL_BYPASS;
      endcase
   end

   // Instruction shifter: captures the fixed pattern, then shifts toward bit zero.
   always_ff @(posedge i_tck or negedge i_rstn) begin
      if (!i_rstn) begin
         ir_shift_q <= tap_pkg::IR_CAPTURE;
      end else if (tck_en) begin
         if (state_q == tap_pkg::ST_CAP_IR) begin
            ir_shift_q <= tap_pkg::IR_CAPTURE;
         end else if (state_q == tap_pkg::ST_SHIFT_IR) begin
            ir_shift_q <= {i_tdi, ir_shift_q[2:1]};
         end
      end
   end

   // Active instruction changes on the falling edge so decode is steady for
   // the whole following high phase.
   always_ff @(negedge i_tck or negedge i_rstn) begin
      if (!i_rstn) begin
         ir_q <= tap_pkg::IR_IDCODE;
      end else if (tck_en) begin
         if (state_q == tap_pkg::ST_RESET) begin
            ir_q <= tap_pkg::IR_IDCODE;
         end else if (state_q == tap_pkg::ST_UPD_IR) begin
            ir_q <= ir_shift_q;
         end
      end
   end

   // Identification register loads its code on capture and shifts out bit zero first.
   always_ff @(posedge i_tck or negedge i_rstn) begin
      if (!i_rstn) begin
         id_shift_q <= '0;
      end else if (tck_en && dr_sel == tap_pkg::SEL_ID) begin
         if (state_q == tap_pkg::ST_CAP_DR) begin
            id_shift_q <= id_value;
         end else if (state_q == tap_pkg::ST_SHIFT_DR) begin
            id_shift_q <= {i_tdi, id_shift_q[tap_pkg::ID_LEN-1:1]};
         end
      end
   end

   // Bypass bit: a single stage, cleared on capture as usual for this cell.
   always_ff @(posedge i_tck or negedge i_rstn) begin
      if (!i_rstn) begin
         bypass_q <= 1'b0;
      end else if (tck_en && dr_sel == tap_pkg::SEL_BYPASS) begin
         if (state_q == tap_pkg::ST_CAP_DR) begin
            bypass_q <= 1'b0;
         end else if (state_q == tap_pkg::ST_SHIFT_DR) begin
            bypass_q <= i_tdi;
         end
      end
   end

   // Boundary chain shift stages, one generate cell per stage; the last stage
   // takes test data in, and stage zero feeds test data out.
   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_cell
         always_ff @(posedge i_tck or negedge i_rstn) begin
            if (!i_rstn) begin
               chain_q[g] <= 1'b0;
            end else if (tck_en && dr_sel == tap_pkg::SEL_CHAIN) begin
               if (state_q == tap_pkg::ST_CAP_DR) begin
                  chain_q[g] <= pin_sync[g];
               end else if (state_q == tap_pkg::ST_SHIFT_DR) begin
                  chain_q[g] <= (g == N - 1) ? i_tdi : chain_q[(g + 1) % N];
               end
            end
         end
      end
   endgenerate

   // Holding stage for the chain, plus a toggle that tells the core domain a
   // new word is ready. The word stays put until the next Update-DR, which
   // is many test clocks away, so the core can copy it without tearing.
   always_ff @(negedge i_tck or negedge i_rstn) begin
      if (!i_rstn) begin
         update_hold_q <= '0;
         update_tgl_q <= 1'b0;
      end else if (tck_en && state_q == tap_pkg::ST_UPD_DR && dr_sel == tap_pkg::SEL_CHAIN) begin
         update_hold_q <= chain_q;
         update_tgl_q <= ~update_tgl_q;
      end
   end

   // External-test mode level, changed only with the active instruction.
   always_ff @(negedge i_tck or negedge i_rstn) begin
      if (!i_rstn) begin
         extest_q <= 1'b0;
      end else if (tck_en) begin
         extest_q <= (ir_q == tap_pkg::IR_EXTEST);
      end
   end

   // Serial output choice for the present shift state.
   always_comb begin
      if (state_q == tap_pkg::ST_SHIFT_IR) begin
         serial_out = ir_shift_q[0];
      end else begin
         case (dr_sel)
            tap_pkg::SEL_CHAIN: serial_out = chain_q[0];
            tap_pkg::SEL_ID: serial_out = id_shift_q[0];
            tap_pkg::SEL_BYPASS: serial_out = bypass_q;
            default: serial_out = bypass_q;
         endcase
      end
   end

   // Test data out is retimed on the falling edge so the tester can sample it
   // on the next rising edge with half a period of margin.
   always_ff @(negedge i_tck or negedge i_rstn) begin
      if (!i_rstn) begin
         o_tdo <= 1'b0;
         o_tdo_oe <= 1'b0;
      end else if (tck_en) begin
         o_tdo <= serial_out;
         o_tdo_oe <= (state_q == tap_pkg::ST_SHIFT_DR) || (state_q == tap_pkg::ST_SHIFT_IR);
      end
   end

   // Core-domain copies of the update toggle and the test mode.
   bit_sync #(.WIDTH(2)) core_sync_u (
      .i_clock(i_clock),
      .i_rstn(i_rstn),
      .i_async({update_tgl_q, extest_q}),
      .o_sync(core_sync)
   );

   // A toggle edge means the holding word is stable; copy it over here.
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         update_seen_q <= 1'b0;
         pin_hold_q <= '0;
      end else if (i_clock_en) begin
         update_seen_q <= core_sync[1];
         if (core_sync[1] != update_seen_q) begin
            pin_hold_q <= update_hold_q;
         end
      end
   end

   // Pin drive: the core path normally, the updated chain under external test.
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         o_pin_drive <= '0;
      end else if (i_clock_en) begin
         o_pin_drive <= core_sync[0] ? pin_hold_q : i_core_drive;
      end
   end

   // Five high mode-select edges with the enable set always land in reset.
   tlr_reach_a: assert property (@(posedge i_tck) disable iff (!i_rstn)
      (tck_en && i_tms) [*5] |=> (state_q == tap_pkg::ST_RESET))
      else $error("controller missed reset after five high edges");

   // Reset state loads the identification instruction.
   ir_reset_a: assert property (@(posedge i_tck) disable iff (!i_rstn)
      (tck_en && state_q == tap_pkg::ST_RESET) |=> (ir_q == tap_pkg::IR_IDCODE))
      else $error("instruction not set to identification in reset");

   // Idle holds with mode select low and leaves for Select-DR-Scan when high.
   idle_hold_a: assert property (@(posedge i_tck) disable iff (!i_rstn)
      (tck_en && state_q == tap_pkg::ST_IDLE) |=>
      (state_q == ($past(i_tms) ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE)))
      else $error("idle state moved wrongly");

   // Bypass shifting delays data by one clock and appears on data out.
   // The bit taken on one rising edge is on data out by the next rising edge.
   bypass_delay_a: assert property (@(posedge i_tck) disable iff (!i_rstn)
      (tck_en && state_q == tap_pkg::ST_SHIFT_DR && dr_sel == tap_pkg::SEL_BYPASS && !i_tms)
      |=> (bypass_q == $past(i_tdi)) && (!tck_en || o_tdo == $past(i_tdi)))
      else $error("bypass path delay wrong");

   // Output enable is high exactly in the two shift states.
   tdo_enable_a: assert property (@(posedge i_tck) disable iff (!i_rstn)
      tck_en |-> (o_tdo_oe == (state_q == tap_pkg::ST_SHIFT_DR || state_q == tap_pkg::ST_SHIFT_IR)))
      else $error("data out enable outside shift states");

   // Captured identification code has bit zero set and the fields in place.
   id_capture_a: assert property (@(posedge i_tck) disable iff (!i_rstn)
      (tck_en && state_q == tap_pkg::ST_CAP_DR && dr_sel == tap_pkg::SEL_ID) |=>
      (id_shift_q[0] == 1'b1 && id_shift_q[tap_pkg::ID_MANUF_LSB +: 11] == MANUF_ID &&
      id_shift_q[tap_pkg::ID_PART_LSB +: 16] == PART_ID &&
      id_shift_q[tap_pkg::ID_REV_LSB +: 4] == REVISION_ID))
      else $error("identification capture wrong");

   // Holding stage moves only in Update-DR with the chain selected.
   hold_update_a: assert property (@(posedge i_tck) disable iff (!i_rstn)
      $changed(update_hold_q) |-> (state_q == tap_pkg::ST_UPD_DR && dr_sel == tap_pkg::SEL_CHAIN))
      else $error("holding stage changed outside update");

   // Instruction bits enter at the top and move toward bit zero.
   ir_shift_a: assert property (@(posedge i_tck) disable iff (!i_rstn)
      (tck_en && state_q == tap_pkg::ST_SHIFT_IR) |=>
      (ir_shift_q == {$past(i_tdi), $past(ir_shift_q[2:1])}))
      else $error("instruction shift order wrong");

   // A new instruction is taken from the shifter on the falling edge in Update-IR.
   ir_update_a: assert property (@(posedge i_tck) disable iff (!i_rstn)
      (tck_en && state_q == tap_pkg::ST_UPD_IR) |=>
      (!tck_en || ir_q == $past(ir_shift_q)))
      else $error("instruction not updated from shifter");

   // Chain stages move one place toward data out on each Shift-DR edge.
   chain_shift_a: assert property (@(posedge i_tck) disable iff (!i_rstn)
      (tck_en && state_q == tap_pkg::ST_SHIFT_DR && dr_sel == tap_pkg::SEL_CHAIN) |=>
      (chain_q == {$past(i_tdi), $past(chain_q[N-1:1])}))
      else $error("boundary chain shift wrong");

   // Chain capture takes the synchronised pin levels.
   chain_capture_a: assert property (@(posedge i_tck) disable iff (!i_rstn)
      (tck_en && state_q == tap_pkg::ST_CAP_DR && dr_sel == tap_pkg::SEL_CHAIN) |=>
      (chain_q == $past(pin_sync)))
      else $error("chain capture missed pin levels");

   // Outside external test the pins follow the core drive one cycle later.
   core_path_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
      (i_clock_en && !core_sync[0]) |=> (o_pin_drive == $past(i_core_drive)))
      else $error("normal pin path disturbed");

   // Under external test the pins carry the word copied from the holding stage.
   extest_drive_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
      (i_clock_en && core_sync[0]) |=> (o_pin_drive == $past(pin_hold_q)))
      else $error("pins not driven from boundary chain");

endmodule : jtag_tap
`default_nettype wire

// file: hw/tap_pkg.sv
// Shared constants and types for the boundary-scan test access port.
// Assumes a test clock from the external tester and a separate core clock.
package tap_pkg;

   // Register lengths.
   localparam int IR_LEN = 3;
   localparam int ID_LEN = 32;
   localparam int CHAIN_LEN = 98;

   // Instruction codes, shifted in least significant bit first.
   localparam logic [2:0] IR_EXTEST = 3'h0;
   localparam logic [2:0] IR_SAMPLE = 3'h4;
   localparam logic [2:0] IR_IDCODE = 3'h6;
   localparam logic [2:0] IR_BYPASS = 3'h7;

   // Value loaded into the instruction shifter during Capture-IR.
   localparam logic [2:0] IR_CAPTURE = 3'h1;

   // Identification field positions.
   localparam int ID_MANUF_LSB = 1;
   localparam int ID_PART_LSB = 12;
   localparam int ID_REV_LSB = 28;

   // Identification code layout, bit zero fixed at one.
   typedef struct packed {
      logic [3:0] revision;
      logic [15:0] part;
      logic [10:0] manufacturer;
      logic one;
   } idcode_t;

   // Controller states.
   typedef enum logic [3:0] {
      ST_RESET = 4'h0,
      ST_IDLE = 4'h1,
      ST_SEL_DR = 4'h2,
      ST_CAP_DR = 4'h3,
      ST_SHIFT_DR = 4'h4,
      ST_EXIT1_DR = 4'h5,
      ST_PAUSE_DR = 4'h6,
      ST_EXIT2_DR = 4'h7,
      ST_UPD_DR = 4'h8,
      ST_SEL_IR = 4'h9,
      ST_CAP_IR = 4'hA,
      ST_SHIFT_IR = 4'hB,
      ST_EXIT1_IR = 4'hC,
      ST_PAUSE_IR = 4'hD,
      ST_EXIT2_IR = 4'hE,
      ST_UPD_IR = 4'hF
   } tap_state_t;

   // Data register selected by the active instruction.
   typedef enum logic [1:0] {
      SEL_BYPASS = 2'h0,
      SEL_CHAIN = 2'h1,
      SEL_ID = 2'h2
   } dr_sel_t;

endpackage : tap_pkg

// file: testbench/jtag_tester.sv
// Behavioural boundary-scan tester that makes the test clock, mode select and data in.
// Assumes the block samples on rising test clock and drives data out on falling clock.
`timescale 1ns/100ps
`default_nettype none
module jtag_tester (
   output logic o_tck,
   output logic o_tms,
   output logic o_tdi,
   input wire logic i_tdo,
   input wire logic i_tdo_oe
);
   int oe_bad;

   // The test clock stands low between frames, as a real tester would leave it.
   initial begin
      o_tck = 1'b0;
      o_tms = 1'b1;
      o_tdi = 1'b0;
      oe_bad = 0;
   end

   // One test clock period; inputs change only while the clock is low.
   task automatic step(input logic tms, input logic tdi, input logic exp_oe, output logic tdo);
      o_tms = tms;
      o_tdi = tdi;
      #40 o_tck = 1'b1;
      // A released data out line shows the inverse, so reading it undriven is caught.
      tdo = i_tdo_oe ? i_tdo : ~i_tdo;
      if (i_tdo_oe !== exp_oe) oe_bad++;
      #40 o_tck = 1'b0;
   endtask : step

   // Outside a shift the data line is flipped, so a stale value cannot pass by luck.
   task automatic move(input logic tms);
      logic d;
      step(tms, ~o_tdi, 1'b0, d);
   endtask : move

   // Five high mode-select edges reach reset from any state, then settle in idle.
   task automatic reset5();
      #1.3;
      repeat (5) move(1'b1);
      move(1'b0);
   endtask : reset5

   // Scans n bits, least significant first, through the instruction or data path.
   task automatic scan(input logic instr, input int n, input logic [97:0] din,
                       output logic [97:0] dout);
      logic d;
      #1.3;
      dout = '0;
      move(1'b1);
      if (instr) move(1'b1);
      move(1'b0);
      move(1'b0);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], 1'b1, d);
         dout[i] = d;
      end
      move(1'b1);
      move(1'b0);
   endtask : scan
endmodule : jtag_tester
`default_nettype wire

// file: testbench/tb.sv
// Self-checking bench for the test access port, driven through a tester model.
// Assumes the tester leaves the controller in Run-Test/Idle after every scan.
`timescale 1ns/100ps
`default_nettype none
`define CHECK(n, e, g) \
   begin \
      total_checks++; \
      if ((g) !== (e)) begin \
         failures++; \
         $display("wrong value %s: expected %h, seen %h", n, e, g); \
      end \
   end
module tb;
   localparam logic [10:0] MANUF = 11'h2A3; // Arbitrary value.
   localparam logic [15:0] PART = 16'h5A0F; // Arbitrary value.
   localparam logic [3:0] REV = 4'h9; // Arbitrary value.
   localparam logic [97:0] PADS = {2'h2, {12{8'hA5}}};
   localparam logic [97:0] CORE = {2'h1, {12{8'h3C}}};
   localparam logic [97:0] PATT = {2'h3, {12{8'h1E}}};
   logic clock, rstn, clock_en, tck, tms, tdi, tdo, tdo_oe;
   logic [tap_pkg::CHAIN_LEN-1:0] pin_level, core_drive, pin_drive, dout;
   int failures, total_checks, cycles;

   jtag_tap #(.MANUF_ID(MANUF), .PART_ID(PART), .REVISION_ID(REV)) dut (
      .i_clock(clock), .i_rstn(rstn), .i_clock_en(clock_en), .i_tck(tck),
      .i_tms(tms), .i_tdi(tdi), .o_tdo(tdo), .o_tdo_oe(tdo_oe),
      .i_pin_level(pin_level), .i_core_drive(core_drive), .o_pin_drive(pin_drive));

   jtag_tester tester (.o_tck(tck), .o_tms(tms), .o_tdi(tdi), .i_tdo(tdo), .i_tdo_oe(tdo_oe));

   // Core clock at 250 MHz.
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   // Prints the counts and the verdict, then stops the run.
   task automatic results();
      $display("checks %0d, mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : results

   // Pin drive crosses into the core domain, so allow a bounded settling time.
   task automatic check_pins(input logic [97:0] e);
      int k;
      k = 0;
      while (pin_drive !== e && k < 20) begin
         @(posedge clock);
         k++;
      end
      `CHECK("pin drive", e, pin_drive)
   endtask : check_pins

   // Clock enable low freezes both domains, so a blind reset attempt must not land.
   task automatic t_freeze();
      @(posedge clock);
      clock_en <= 1'b0;
      core_drive <= ~CORE;
      repeat (3) tester.move(1'b0);
      repeat (5) tester.move(1'b1);
      `CHECK("frozen pins", CORE, pin_drive)
      @(posedge clock);
      clock_en <= 1'b1;
      repeat (3) tester.move(1'b0);
      tester.scan(1'b0, 8, 98'hB5, dout);
      `CHECK("frozen bypass", 8'h6A, dout[7:0])
      check_pins(~CORE);
   endtask : t_freeze

   // Reads the identification code with the current instruction.
   task automatic t_idcode();
      tester.scan(1'b0, 32, '0, dout);
      `CHECK("identification", {REV, PART, MANUF, 1'b1}, dout[31:0])
   endtask : t_idcode

   // Every code outside the defined set must act as the one-stage bypass.
   task automatic t_bypass();
      logic [2:0] codes [5] = '{3'h1, 3'h2, 3'h3, 3'h5, tap_pkg::IR_BYPASS};
      foreach (codes[i]) begin
         tester.scan(1'b1, 3, {95'h0, codes[i]}, dout);
         `CHECK("instruction capture", tap_pkg::IR_CAPTURE, dout[2:0])
         tester.scan(1'b0, 8, 98'hB5, dout);
         `CHECK("bypass delay", 8'h6A, dout[7:0])
      end
   endtask : t_bypass

   // Sample captures the pads and preloads the chain while pins keep the core path.
   task automatic t_sample();
      @(posedge clock);
      pin_level <= PADS;
      core_drive <= CORE;
      tester.scan(1'b1, 3, {95'h0, tap_pkg::IR_SAMPLE}, dout);
      tester.scan(1'b0, 98, PATT, dout);
      `CHECK("sampled pads", PADS, dout)
      check_pins(CORE);
   endtask : t_sample

   // External test drives pins from the held word, first the preloaded one.
   task automatic t_extest();
      tester.scan(1'b1, 3, {95'h0, tap_pkg::IR_EXTEST}, dout);
      check_pins(PATT);
      tester.scan(1'b0, 98, ~PATT, dout);
      `CHECK("captured pads", PADS, dout)
      check_pins(~PATT);
      repeat (4) tester.move(1'b0);
      `CHECK("held pins", ~PATT, pin_drive)
      tester.scan(1'b1, 3, {95'h0, tap_pkg::IR_BYPASS}, dout);
      check_pins(CORE);
   endtask : t_extest

   // Reset through mode select from Pause-DR must restore the identification code.
   task automatic t_abort();
      logic d;
      tester.scan(1'b1, 3, {95'h0, tap_pkg::IR_BYPASS}, dout);
      tester.move(1'b1);
      tester.move(1'b0);
      tester.move(1'b0);
      tester.step(1'b1, 1'b1, 1'b1, d);
      tester.move(1'b0);
      tester.reset5();
      t_idcode();
   endtask : t_abort

   // A hang is cut short here and counted as a mismatch.
   always @(posedge clock) begin
      cycles++;
      if (cycles == 30000) begin
         failures++;
         $display("wrong value run time: expected %0d, seen %0d", 29999, cycles);
         results();
      end
   end

   // Main sequence.
   initial begin
      rstn = 1'b0;
      clock_en = 1'b1;
      pin_level = '0;
      core_drive = '0;
      dout = '0;
      failures = 0;
      total_checks = 0;
      cycles = 0;
      repeat (2) @(posedge clock);
      rstn <= 1'b1;
      tester.reset5();
      t_idcode();
      t_bypass();
      t_sample();
      t_extest();
      t_freeze();
      t_abort();
      `CHECK("enable faults", 0, tester.oe_bad)
      results();
   end
endmodule : tb
`default_nettype wire
